// ### verilog/mmu_pkg.sv
// constants, field layout and state types of the translation unit
package mmu_pkg;

  localparam int VA_W        = 32;
  localparam int TAG_W       = 22;
  localparam int TID_W       = 8;
  localparam int HI_W        = 36;
  localparam int LO_W        = 32;
  localparam int ATTR_W      = 6;
  localparam int ZONE_IDX_W  = 4;

  // entry high word; tag bit 0 is its msb
  localparam int HI_TAG_LSB  = 14;
  localparam int HI_SIZE_LSB = 11;
  localparam int HI_V_BIT    = 10;
  localparam int HI_E_BIT    = 9;
  localparam int HI_U0_BIT   = 8;
  localparam int HI_TID_LSB  = 0;

  // entry low word (data side)
  localparam int LO_RPN_LSB  = 10;
  localparam int LO_EX_BIT   = 9;
  localparam int LO_WR_BIT   = 8;
  localparam int LO_ZONE_LSB = 4;
  localparam int LO_W_BIT    = 3;
  localparam int LO_I_BIT    = 2;
  localparam int LO_M_BIT    = 1;
  localparam int LO_G_BIT    = 0;

  // size code 0 is a 1 KB page; each step multiplies by four
  localparam int MIN_OFFSET_BITS = 10;
  localparam int SIZE_STEP       = 2;

  localparam int MAIN_ENTRIES = 64;
  localparam int WALK_WAYS    = 8;
  localparam int SHADOW_DEPTH = 4;
  localparam int ZONES        = 16;
  localparam int NUM_PORTS    = 2;
  localparam int PORT_LS      = 0;
  localparam int PORT_IF      = 1;

  localparam logic [1:0]      ZONE_NO_ACCESS = 2'h0;
  localparam logic [1:0]      ZONE_OVR_PRIV  = 2'h2;
  localparam logic [1:0]      ZONE_OVR_ALL   = 2'h3;
  localparam logic [TID_W-1:0] TID_GLOBAL    = 8'h00;

  localparam logic [VA_W-1:0] ZPR_RST = 32'h00000000;
  localparam logic            VM_RST  = 1'b0;

  typedef enum logic [2:0] {
    P_IDLE = 3'h1,
    P_LOOK = 3'h2,
    P_WAIT = 3'h4
  } port_state_t;

  typedef enum logic [1:0] {
    W_IDLE = 2'h1,
    W_SCAN = 2'h2
  } walk_state_t;

  // ones over the page offset selected by a size code
  function automatic logic [VA_W-1:0] offset_mask(input logic [2:0] size);
    offset_mask = ~(32'hffffffff << (MIN_OFFSET_BITS + SIZE_STEP * int'(size)));
  endfunction : offset_mask

endpackage : mmu_pkg

// ### verilog/entry_match.sv
// hit test and physical address of one translation entry
`timescale 1ns/1ps
`default_nettype none
module entry_match (
  input  wire logic                       ent_valid,
  input  wire logic [mmu_pkg::HI_W-1:0]   ent_hi,
  input  wire logic [mmu_pkg::LO_W-1:0]   ent_lo,
  input  wire logic [mmu_pkg::VA_W-1:0]   look_va,
  input  wire logic [mmu_pkg::TID_W-1:0]  look_pid,
  output logic                            hit,
  output logic      [mmu_pkg::VA_W-1:0]   paddr
);
  import mmu_pkg::*;

  logic [VA_W-1:0]  omask;
  logic [VA_W-1:0]  tag_full;
  logic [VA_W-1:0]  rpn_full;
  logic [TID_W-1:0] entry_process_number;
  logic             tag_ok;
  logic             pid_ok;

  assign omask    = offset_mask(ent_hi[HI_SIZE_LSB +: 3]);
  assign tag_full = {ent_hi[HI_TAG_LSB +: TAG_W], 10'h000};
  assign rpn_full = {ent_lo[LO_RPN_LSB +: TAG_W], 10'h000};
  assign entry_process_number      = ent_hi[HI_TID_LSB +: TID_W];

  // bits above the page offset only; size 0 uses all 22
  assign tag_ok = ((tag_full ^ look_va) & ~omask) == '0;
  // a global entry ignores the process; process 0 only meets globals
  assign pid_ok = (entry_process_number == TID_GLOBAL) || (entry_process_number == look_pid);
  assign hit    = ent_valid && ent_hi[HI_V_BIT] && tag_ok && pid_ok;

  // frame bits above the offset, address bits within it
  assign paddr = (rpn_full & ~omask) | (look_va & omask);

endmodule : entry_match
`default_nettype wire

// ### verilog/shadow_table.sv
// small fully associative shadow table filled by hardware
`timescale 1ns/1ps
`default_nettype none
module shadow_table #(
  parameter int DEPTH = mmu_pkg::SHADOW_DEPTH
) (
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  input  wire logic                       flush,
  input  wire logic                       fill_en,
  input  wire logic [mmu_pkg::HI_W-1:0]   fill_hi,
  input  wire logic [mmu_pkg::LO_W-1:0]   fill_lo,
  input  wire logic [mmu_pkg::VA_W-1:0]   look_va,
  input  wire logic [mmu_pkg::TID_W-1:0]  look_pid,
  output logic                            hit,
  output logic      [mmu_pkg::LO_W-1:0]   hit_lo,
  output logic      [mmu_pkg::VA_W-1:0]   hit_paddr
);
  import mmu_pkg::*;

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [HI_W-1:0]  hi_r [DEPTH];
  logic [LO_W-1:0]  lo_r [DEPTH];
  logic [DEPTH-1:0] val_r;
  logic [PTR_W-1:0] rr_r;
  logic [DEPTH-1:0] e_hit;
  logic [VA_W-1:0]  e_pa [DEPTH];

  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    entry_match u_match (
      .ent_valid (val_r[i]),
      .ent_hi    (hi_r[i]),
      .ent_lo    (lo_r[i]),
      .look_va   (look_va),
      .look_pid  (look_pid),
      .hit       (e_hit[i]),
      .paddr     (e_pa[i])
    );
  end

  // two matches are a software fault; the highest-index match wins
  always_comb begin
    hit       = 1'b0;
    hit_lo    = '0;
    hit_paddr = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (e_hit[i]) begin
        hit       = 1'b1;
        hit_lo    = lo_r[i];
        hit_paddr = e_pa[i];
      end
    end
  end

  // round robin victim; flush wins over a fill in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b || flush) begin
      val_r <= '0;
      rr_r  <= '0;
    end else if (fill_en) begin
      val_r[rr_r] <= 1'b1;
      rr_r        <= (int'(rr_r) == DEPTH - 1) ? '0 : rr_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (fill_en) begin
      hi_r[rr_r] <= fill_hi;
      lo_r[rr_r] <= fill_lo;
    end
  end

endmodule : shadow_table
`default_nettype wire

// ### verilog/tlb_lookup_access_protection.sv
// translation lookup and access protection unit of the processor
//
// Contract
// - shadow table first, main table on miss
// - main table miss stalls two to thirty-two cycles
// - load/store wins main table over fetch
// - hit needs valid, tag match, process match
// - global entry skips the process comparison
// - process zero hits only global entries
// - 1 KB page compares all 22 tag bits
// - physical address is frame bits plus offset
// - check access first, then apply storage attributes
// - exception clears translate bit, entering real mode
// - user access to no-access zone faults data
// - store to read-only page faults unless overridden
// - guarded, no-access or non-runnable fetch faults; here a non-runnable fetch only raises if_no_run
// - load/store finding no entry raises data miss
// - fetch finding no entry raises fetch miss
// - run-permit fault only when instruction executes
// - privileged loads are never read-blocked
// - zone index picks field of override register
// - unimplemented zones read as override all
// - main table holds 64 shared entries
//
// Local design decisions: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module tlb_lookup_access_protection #(
  parameter int IMPL_ZONES = mmu_pkg::ZONES,
  parameter int SH_DEPTH   = mmu_pkg::SHADOW_DEPTH
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_b,
  // load/store stage
  input  wire logic                        ls_req,
  input  wire logic [mmu_pkg::VA_W-1:0]    ls_addr,
  input  wire logic                        ls_store,
  input  wire logic                        ls_user,
  output logic                             ls_ready,
  output logic                             ls_done,
  output logic      [mmu_pkg::VA_W-1:0]    ls_paddr,
  output logic                             ls_miss,
  output logic                             ls_fault,
  output logic                             ls_go,
  output logic      [mmu_pkg::ATTR_W-1:0]  ls_attr,
  // fetch stage
  input  wire logic                        if_req,
  input  wire logic [mmu_pkg::VA_W-1:0]    if_addr,
  input  wire logic                        if_user,
  output logic                             if_ready,
  output logic                             if_done,
  output logic      [mmu_pkg::VA_W-1:0]    if_paddr,
  output logic                             if_miss,
  output logic                             if_fault,
  output logic                             if_no_run,
  output logic      [mmu_pkg::ATTR_W-1:0]  if_attr,
  // execute stage returns the run tag
  input  wire logic                        exec_valid,
  input  wire logic                        exec_no_run,
  output logic                             fetch_protection_fault,
  // mode, process and zone state
  input  wire logic                        exc_taken,
  input  wire logic                        vm_set,
  output logic                             translate_on_bit,
  input  wire logic [mmu_pkg::TID_W-1:0]   current_process_number,
  input  wire logic                        zpr_wr,
  input  wire logic [mmu_pkg::VA_W-1:0]    zpr_wdata,
  // main table load port
  input  wire logic                        tbl_wr,
  input  wire logic [5:0]                  tbl_idx,
  input  wire logic [mmu_pkg::HI_W-1:0]    tbl_hi,
  input  wire logic [mmu_pkg::LO_W-1:0]    tbl_lo
);
  import mmu_pkg::*;

  localparam int PASSES = MAIN_ENTRIES / WALK_WAYS;
  localparam int PASS_W = $clog2(PASSES);
  localparam int IDX_W  = $clog2(MAIN_ENTRIES);

  ////////////////////////////////////////////////////////////////////////
  // mode and zone override register

  logic            vm_r;
  logic [VA_W-1:0] zone_override_register_r;

  // exception wins over a simultaneous set
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      vm_r <= VM_RST;
    end else if (exc_taken) begin
      vm_r <= 1'b0;
    end else if (vm_set) begin
      vm_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      zone_override_register_r <= ZPR_RST;
    end else if (zpr_wr) begin
      zone_override_register_r <= zpr_wdata;
    end
  end

  assign translate_on_bit = vm_r;

  function automatic logic [1:0] zone_of(input logic [ZONE_IDX_W-1:0] zi,
                                         input logic [VA_W-1:0]     zr);
    if (int'(zi) >= IMPL_ZONES) begin
      zone_of = ZONE_OVR_ALL;
    end else begin
      zone_of = zr[VA_W - 1 - SIZE_STEP * int'(zi) -: 2];
    end
  endfunction : zone_of

  ////////////////////////////////////////////////////////////////////////
  // main translation table, shared by fetch and data

  logic [HI_W-1:0]         main_hi [MAIN_ENTRIES];
  logic [LO_W-1:0]         main_lo [MAIN_ENTRIES];
  logic [MAIN_ENTRIES-1:0] main_val_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      main_val_r <= '0;
    end else if (tbl_wr) begin
      main_val_r[tbl_idx] <= tbl_hi[HI_V_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (tbl_wr) begin
      main_hi[tbl_idx] <= tbl_hi;
      main_lo[tbl_idx] <= tbl_lo;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-port request capture and shadow lookup

  port_state_t     st_r    [NUM_PORTS];
  logic [VA_W-1:0] va_r    [NUM_PORTS];
  logic            user_r  [NUM_PORTS];
  logic            store_r [NUM_PORTS];
  logic [TID_W-1:0] pid_r  [NUM_PORTS];

  logic            in_req   [NUM_PORTS];
  logic [VA_W-1:0] in_addr  [NUM_PORTS];
  logic            in_user  [NUM_PORTS];
  logic            in_store [NUM_PORTS];

  logic            sh_hit [NUM_PORTS];
  logic [LO_W-1:0] sh_lo  [NUM_PORTS];
  logic [VA_W-1:0] sh_pa  [NUM_PORTS];

  logic            done_r  [NUM_PORTS];
  logic [VA_W-1:0] pa_r    [NUM_PORTS];
  logic            miss_r  [NUM_PORTS];
  logic            fault_r [NUM_PORTS];
  logic            norun_r [NUM_PORTS];
  logic [ATTR_W-1:0] attr_r [NUM_PORTS];

  logic [NUM_PORTS-1:0] walk_req;

  // walker results
  walk_state_t      wst_r;
  logic             owner_r;
  logic [PASS_W-1:0] pass_r;
  logic             wdone_r;
  logic             whit_r;
  logic [HI_W-1:0]  whi_r;
  logic [LO_W-1:0]  wlo_r;
  logic [VA_W-1:0]  wpa_r;

  assign in_req[PORT_LS]   = ls_req;
  assign in_addr[PORT_LS]  = ls_addr;
  assign in_user[PORT_LS]  = ls_user;
  assign in_store[PORT_LS] = ls_store;
  assign in_req[PORT_IF]   = if_req;
  assign in_addr[PORT_IF]  = if_addr;
  assign in_user[PORT_IF]  = if_user;
  assign in_store[PORT_IF] = 1'b0;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic            res_v;
    logic            res_real;
    logic            res_miss;
    logic [LO_W-1:0] res_lo;
    logic [VA_W-1:0] res_pa;
    logic            fill;
    logic [1:0]      zone;
    logic            wr_ovr;
    logic            zone_block;
    logic            ls_flt;
    logic            if_flt;
    logic            no_run;
    logic            allowed;
    logic            mine;
    logic [1:0]      e_u0;

    assign mine = wdone_r && (int'(owner_r) == p);

    shadow_table #(
      .DEPTH (SH_DEPTH)
    ) u_shadow (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .flush     (tbl_wr),
      .fill_en   (fill),
      .fill_hi   (whi_r),
      .fill_lo   (wlo_r),
      .look_va   (va_r[p]),
      .look_pid  (pid_r[p]),
      .hit       (sh_hit[p]),
      .hit_lo    (sh_lo[p]),
      .hit_paddr (sh_pa[p])
    );

    always_comb begin
      res_v    = 1'b0;
      res_real = 1'b0;
      res_miss = 1'b0;
      res_lo   = '0;
      res_pa   = va_r[p];
      fill     = 1'b0;
      case (st_r[p])
        P_LOOK: begin
          if (!vm_r) begin
            res_v    = 1'b1;
            res_real = 1'b1;
          end else if (sh_hit[p]) begin
            res_v  = 1'b1;
            res_lo = sh_lo[p];
            res_pa = sh_pa[p];
          end
        end
        P_WAIT: begin
          if (mine) begin
            res_v = 1'b1;
            if (whit_r) begin
              res_lo = wlo_r;
              res_pa = wpa_r;
              fill   = 1'b1;
            end else begin
              res_miss = 1'b1;
            end
          end
        end
        default: begin
          res_v = 1'b0;
        end
      endcase
    end

    // the zone may widen the entry's rights; 01 keeps them
    assign zone   = zone_of(res_lo[LO_ZONE_LSB +: ZONE_IDX_W],
                            zone_override_register_r);
    assign wr_ovr = (zone == ZONE_OVR_ALL) ||
                    (!user_r[p] && zone == ZONE_OVR_PRIV);
    assign zone_block = user_r[p] && (zone == ZONE_NO_ACCESS);
    assign ls_flt = zone_block ||
                    (store_r[p] && !res_lo[LO_WR_BIT] && !wr_ovr);
    assign if_flt = res_lo[LO_G_BIT] || zone_block;
    assign no_run = !res_lo[LO_EX_BIT] && !wr_ovr;
    assign allowed = !res_real && !res_miss &&
                     !((p == PORT_LS) ? ls_flt : if_flt);
    assign walk_req[p] = (st_r[p] == P_WAIT) && !mine;
    // shadow hits carry no high word: e and u0 read 0
    assign e_u0 = mine ? {whi_r[HI_E_BIT], whi_r[HI_U0_BIT]} : 2'h0;

    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        st_r[p] <= P_IDLE;
      end else begin
        case (st_r[p])
          P_IDLE: begin
            if (in_req[p]) begin
              st_r[p] <= P_LOOK;
            end
          end
          P_LOOK: begin
            st_r[p] <= res_v ? P_IDLE : P_WAIT;
          end
          P_WAIT: begin
            if (res_v) begin
              st_r[p] <= P_IDLE;
            end
          end
          default: begin
            st_r[p] <= P_IDLE;
          end
        endcase
      end
    end

    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        va_r[p]    <= '0;
        user_r[p]  <= 1'b0;
        store_r[p] <= 1'b0;
        pid_r[p]   <= '0;
      end else if (st_r[p] == P_IDLE && in_req[p]) begin
        va_r[p]    <= in_addr[p];
        user_r[p]  <= in_user[p];
        store_r[p] <= in_store[p];
        pid_r[p]   <= current_process_number;
      end
    end

    // attributes go out only for a permitted access
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        done_r[p]  <= 1'b0;
        pa_r[p]    <= '0;
        miss_r[p]  <= 1'b0;
        fault_r[p] <= 1'b0;
        norun_r[p] <= 1'b0;
        attr_r[p]  <= '0;
      end else begin
        done_r[p]  <= res_v;
        pa_r[p]    <= res_pa;
        miss_r[p]  <= res_v && res_miss;
        fault_r[p] <= res_v && !res_real && !res_miss &&
                      ((p == PORT_LS) ? ls_flt : if_flt);
        norun_r[p] <= res_v && !res_real && !res_miss &&
                      (p == PORT_IF) && no_run;
        attr_r[p]  <= allowed ? {res_lo[LO_W_BIT], res_lo[LO_I_BIT],
                                 res_lo[LO_M_BIT], res_lo[LO_G_BIT],
                                 e_u0} : '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // main table walker, WALK_WAYS entries per cycle

  logic [IDX_W-1:0]     widx [WALK_WAYS];
  logic [WALK_WAYS-1:0] w_hit;
  logic [VA_W-1:0]      w_pa [WALK_WAYS];
  logic                 any_hit;
  logic [HI_W-1:0]      sel_hi;
  logic [LO_W-1:0]      sel_lo;
  logic [VA_W-1:0]      sel_pa;

  for (genvar k = 0; k < WALK_WAYS; k++) begin : g_way
    assign widx[k] = IDX_W'(int'(pass_r) * WALK_WAYS + k);
    entry_match u_match (
      .ent_valid (main_val_r[widx[k]]),
      .ent_hi    (main_hi[widx[k]]),
      .ent_lo    (main_lo[widx[k]]),
      .look_va   (va_r[owner_r]),
      .look_pid  (pid_r[owner_r]),
      .hit       (w_hit[k]),
      .paddr     (w_pa[k])
    );
  end

  always_comb begin
    any_hit = 1'b0;
    sel_hi  = '0;
    sel_lo  = '0;
    sel_pa  = '0;
    for (int k = 0; k < WALK_WAYS; k++) begin
      if (w_hit[k]) begin
        any_hit = 1'b1;
        sel_hi  = main_hi[widx[k]];
        sel_lo  = main_lo[widx[k]];
        sel_pa  = w_pa[k];
      end
    end
  end

  // no grant while a result is out; its port no longer asks
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wst_r   <= W_IDLE;
      owner_r <= 1'b0;
      pass_r  <= '0;
      wdone_r <= 1'b0;
      whit_r  <= 1'b0;
      whi_r   <= '0;
      wlo_r   <= '0;
      wpa_r   <= '0;
    end else begin
      wdone_r <= 1'b0;
      case (wst_r)
        W_IDLE: begin
          pass_r <= '0;
          if (!wdone_r && walk_req[PORT_LS]) begin
            owner_r <= 1'(PORT_LS);
            wst_r   <= W_SCAN;
          end else if (!wdone_r && walk_req[PORT_IF]) begin
            owner_r <= 1'(PORT_IF);
            wst_r   <= W_SCAN;
          end
        end
        W_SCAN: begin
          if (any_hit || int'(pass_r) == PASSES - 1) begin
            wdone_r <= 1'b1;
            whit_r  <= any_hit;
            whi_r   <= sel_hi;
            wlo_r   <= sel_lo;
            wpa_r   <= sel_pa;
            wst_r   <= W_IDLE;
          end else begin
            pass_r <= pass_r + 1'b1;
          end
        end
        default: begin
          wst_r <= W_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // execute-time run-permit fault

  logic fpf_r;

  // only for an instruction that runs
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      fpf_r <= 1'b0;
    end else begin
      fpf_r <= exec_valid && exec_no_run;
    end
  end

  assign fetch_protection_fault = fpf_r;

  assign ls_ready  = st_r[PORT_LS][0];
  assign ls_done   = done_r[PORT_LS];
  assign ls_paddr  = pa_r[PORT_LS];
  assign ls_miss   = miss_r[PORT_LS];
  assign ls_fault  = fault_r[PORT_LS];
  assign ls_attr   = attr_r[PORT_LS];
  assign if_ready  = st_r[PORT_IF][0];
  assign if_done   = done_r[PORT_IF];
  assign if_paddr  = pa_r[PORT_IF];
  assign if_miss   = miss_r[PORT_IF];
  assign if_fault  = fault_r[PORT_IF];
  assign if_no_run = norun_r[PORT_IF];
  assign if_attr   = attr_r[PORT_IF];

  logic go_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      go_r <= 1'b0;
    end else begin
      go_r <= g_port[PORT_LS].res_v && !g_port[PORT_LS].res_miss &&
              !(g_port[PORT_LS].ls_flt && !g_port[PORT_LS].res_real);
    end
  end

  assign ls_go = go_r;

endmodule : tlb_lookup_access_protection
`default_nettype wire

// ### verif/tlb_assertions.sv
// port-level checks of the translation unit
`timescale 1ns/1ps
`default_nettype none
module tlb_chk (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        ls_req,
  input wire logic        ls_ready,
  input wire logic [31:0] ls_addr,
  input wire logic        ls_done,
  input wire logic [31:0] ls_paddr,
  input wire logic        ls_miss,
  input wire logic        ls_fault,
  input wire logic        ls_go,
  input wire logic [5:0]  ls_attr,
  input wire logic        if_req,
  input wire logic        if_ready,
  input wire logic        if_done,
  input wire logic        exec_valid,
  input wire logic        exec_no_run,
  input wire logic        fetch_protection_fault,
  input wire logic        exc_taken,
  input wire logic        vm_set,
  input wire logic        translate_on_bit
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_ls_wait_bound: assert property (ls_req && ls_ready |-> ##[2:32] ls_done)
    else $error("ls answer late");
  a_if_wait_bound: assert property (if_req && if_ready |-> ##[2:32] if_done)
    else $error("if answer late");
  a_ls_taken: assert property (ls_req && ls_ready |=> !ls_ready [*1])
    else $error("ls request not taken");
  a_go_blocked: assert property (ls_done && (ls_miss || ls_fault) |-> !ls_go && ls_attr == 6'h00)
    else $error("access went ahead");
  a_real_pass: assert property ((ls_req && ls_ready && !translate_on_bit
    && !vm_set) ##1 !vm_set |=> ls_done && ls_go && ls_paddr == $past(ls_addr, 2))
    else $error("real mode translated");
  a_exc_clear: assert property (exc_taken |=> !translate_on_bit)
    else $error("mode bit kept");
  a_run_fault: assert property (exec_valid && exec_no_run |=> fetch_protection_fault)
    else $error("run fault missing");
  a_no_spec_fault: assert property (!(exec_valid && exec_no_run) |=> !fetch_protection_fault)
    else $error("stray run fault");
endmodule : tlb_chk
`default_nettype wire

// ### verif/exec_stage_model.sv
// execute stage model that hands back the last fetch tag
`timescale 1ns/1ps
`default_nettype none
module exec_stage_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic if_done,
  input wire logic if_no_run,
  input wire logic run,
  output logic     exec_valid,
  output logic     exec_no_run
);
  logic tag_r;
  // one instruction deep: a later fetch overwrites an unexecuted tag
  always_ff @(posedge ref_clk) begin
    if (!rst_b) tag_r <= 1'b0;
    else if (if_done) tag_r <= if_no_run;
  end
  assign exec_valid = run;
  assign exec_no_run = run && tag_r;
endmodule : exec_stage_model
`default_nettype wire

// ### verif/tlb_lookup_access_protection_tb.sv
// self-checking bench of the translation unit
`timescale 1ns/1ps
`default_nettype none
module tlb_lookup_access_protection_tb;
  logic ref_clk = 0, rst_b = 0, ls_req = 0, ls_store = 0, ls_user = 0;
  logic if_req = 0, if_user = 0, exc_taken = 0, vm_set = 0, zpr_wr = 0;
  logic tbl_wr = 0, run = 0, e, exec_valid, exec_no_run;
  logic [31:0] ls_addr = 0, if_addr = 0, zpr_wdata = 0, tbl_lo = 0;
  logic [35:0] tbl_hi = 0;
  logic [7:0]  current_process_number = 0;
  logic [5:0]  tbl_idx = 0, ls_attr, if_attr;
  logic [31:0] ls_paddr, if_paddr;
  logic ls_ready, ls_done, ls_miss, ls_fault, ls_go, if_ready, if_done;
  logic if_miss, if_fault, if_no_run, fetch_protection_fault;
  logic translate_on_bit;
  int fail_count = 0, num_checks = 0, cyc = 0, n;
  always #2.5 ref_clk = ~ref_clk;
  tlb_lookup_access_protection #(.IMPL_ZONES(12)) dut_u (.*);
  exec_stage_model pm_u (.ref_clk, .rst_b, .if_done, .if_no_run, .run,
    .exec_valid, .exec_no_run);
  task automatic chk(input logic c, input string s);
    num_checks++;
    if (c !== 1'b1) begin
      fail_count++;
      $display("ERROR %0t %s", $time, s);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  // k counts edges from the take edge to the done cycle
  task automatic xl(input logic p, input logic [31:0] a,
                    input logic st, us, output int k);
    @(posedge ref_clk);
    {ls_req, if_req, ls_store, ls_user, if_user} <= {!p, p, st, us, us};
    {ls_addr, if_addr} <= {a, a};
    @(posedge ref_clk);
    {ls_req, if_req} <= 2'b00;
    k = 1;
    do begin
      @(posedge ref_clk);
      #1 k++;
    end while ((p ? if_done : ls_done) !== 1'b1 && k < 40);
  endtask : xl
  task automatic ent(input logic [5:0] i, input logic [21:0] t,
                     input logic [2:0] s, input logic [7:0] d,
                     input logic [31:0] l);
    @(posedge ref_clk);
    {tbl_wr, tbl_idx, tbl_hi, tbl_lo} <= {1'b1, i, t, s, 3'h4, d, l};
    @(posedge ref_clk);
    tbl_wr <= 0;
  endtask : ent
  task automatic zp(input logic [31:0] v);
    @(posedge ref_clk);
    {zpr_wr, zpr_wdata} <= {1'b1, v};
    @(posedge ref_clk);
    zpr_wr <= 0;
  endtask : zp
  ////////////////////////////////////////////////////////////////////////
  task automatic t_miss;
    xl(0, 32'h9000_0000, 1, 1, n);
    chk(n == 2 && ls_paddr === 32'h9000_0000 && ls_go === 1, "real");
    @(posedge ref_clk);
    vm_set <= 1;
    @(posedge ref_clk);
    vm_set <= 0;
    xl(0, 32'h4000_0000, 0, 0, n);
    chk(n == 12 && ls_miss === 1 && ls_go === 0, "ls miss");
    xl(1, 32'h4000_0000, 0, 0, n);
    chk(n == 12 && if_miss === 1, "if miss");
    @(posedge ref_clk);
    {ls_req, if_req} <= 2'b11;
    @(posedge ref_clk);
    {ls_req, if_req} <= 2'b00;
    repeat (11) @(posedge ref_clk);
    #1 chk(ls_done === 1 && if_done === 0, "order");
    repeat (25) @(posedge ref_clk);
  endtask : t_miss
  task automatic t_page;
    current_process_number <= 8'h07;
    ent(5, 22'h048d15, 3'h0, 8'h00, {22'h2abcde, 2'h3, 8'h00});
    xl(0, {22'h048d15, 10'h2a7}, 1, 0, n);
    chk(n >= 5 && n <= 12 && ls_paddr === {22'h2abcde, 10'h2a7}, "1k");
    xl(0, {22'h048d15, 10'h2a7}, 1, 0, n);
    chk(n == 2 && ls_go === 1, "shadow");
    xl(0, {22'h048d14, 10'h2a7}, 1, 0, n);
    chk(ls_miss === 1, "tag");
    // unused frame bits written as zero
    ent(6, 22'h3c0000, 3'h4, 8'h00, {22'h155500, 2'h3, 8'h0e});
    xl(0, 32'hf003_abcd, 0, 0, n);
    chk(ls_paddr === {14'h1555, 18'h3abcd} && ls_attr === 6'h38, "256k");
  endtask : t_page
  task automatic t_pid;
    ent(7, 22'h100000, 3'h0, 8'h03, {22'h000001, 2'h3, 8'h00});
    for (int i = 0; i < 3; i++) begin
      current_process_number <= (i == 0) ? 8'h03 : (i == 1) ? 8'h04 : 8'h00;
      xl(0, 32'h4000_0000, 0, 0, n);
      chk(ls_miss === (i != 0), "pid");
    end
  endtask : t_pid
  task automatic t_zone;
    ent(8, 22'h140000, 3'h0, 8'h00, {22'h000002, 2'h2, 4'h2, 4'h0});
    for (int z = 0; z < 4; z++) begin
      zp(32'(z) << 26);
      for (int c = 0; c < 4; c++) begin
        xl(0, 32'h5000_0000, c[1], c[0], n);
        e = c[1] ? (c[0] ? z != 3 : z < 2) : (c[0] && z == 0);
        chk(ls_fault === e && ls_go === !e, "zone");
      end
    end
    ent(9, 22'h180000, 3'h0, 8'h00, {22'h000003, 2'h2, 4'hd, 4'h0});
    zp(32'h0);
    xl(0, 32'h6000_0000, 1, 1, n);
    chk(ls_fault === 0 && ls_go === 1, "zone 13");
  endtask : t_zone
  task automatic t_fetch;
    ent(10, 22'h1c0000, 3'h0, 8'h00, {22'h000004, 2'h1, 4'h1, 4'h0});
    xl(1, 32'h7000_0000, 0, 0, n);
    chk(if_fault === 0 && if_no_run === 1 && fetch_protection_fault === 0, "tag");
    @(posedge ref_clk);
    run <= 1;
    @(posedge ref_clk);
    run <= 0;
    #1 chk(fetch_protection_fault === 1, "run");
    xl(1, 32'h7000_0000, 0, 1, n);
    chk(if_fault === 1 && if_paddr === 32'h1000, "no access");
    ent(11, 22'h200000, 3'h0, 8'h00, {22'h000005, 2'h3, 4'h0, 4'h1});
    xl(1, 32'h8000_0000, 0, 0, n);
    chk(if_fault === 1 && if_attr === 0, "guard");
    @(posedge ref_clk);
    exc_taken <= 1;
    @(posedge ref_clk);
    exc_taken <= 0;
    #1 chk(translate_on_bit === 0, "exc");
  endtask : t_fetch
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1;
    t_miss;
    t_page;
    t_pid;
    t_zone;
    t_fetch;
    test_done;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      test_done;
    end
  end
endmodule : tlb_lookup_access_protection_tb
bind tlb_lookup_access_protection tlb_chk chk_u (.ref_clk, .rst_b, .ls_req,
  .ls_ready, .ls_addr, .ls_done, .ls_paddr, .ls_miss, .ls_fault, .ls_go,
  .ls_attr, .if_req, .if_ready, .if_done, .exec_valid, .exec_no_run,
  .fetch_protection_fault, .exc_taken, .vm_set, .translate_on_bit);
`default_nettype wire
